// File: secure_loader_key_lock_manager.sv
/*
 key, security lock, vector ram and loader command engine.
 assumes a classic wishbone master, an encryptor and ram outside that
 take key_out and mem_req, give read data in the same cycle as a read request,
 and ring oscillator samples already in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "loader_params.svh"
// Notes on behaviour
// - key only from internal random bits
// - key taken at the first memory command, or after the U or kill erase
// - random bits from oscillator mismatch
// - vectors fetched from on-chip 48 bytes
// - dummy external reads during vector fetch
// - loaded vectors copied into vector ram
// - lock set by Z, loader refuses access
// - encryptor also blocked while locked
// - U clears lock, key, vectors at once
// - U erases ram then installs fresh key
// - redundant lock; loss starts erase sequence
// - tamper clears lock, key, vectors and erases ram; nv registers kept
// - tamper briefly drops memory bus supply
// - mesh breach erases lock and key
// - loader entry zeroes scratchpad portion
// - loader entry draws 64-bit candidate key
// - memory commands refused while locked
// - C returns CRC-16 of true contents
// - F L D V C install candidate key
// - key fixed for the session until U, N or a kill wipes it
// - dump and verify on decrypted data
// - N seals, losing all contents
// - R and W reach four nv registers
// - both encryptors share the key
module secure_loader_key_lock_manager #(
	parameter int MEM_WORDS = `MEM_WORDS_DEF,
	parameter int SCRATCH_CLR = `SCRATCH_CLR_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic loader_mode,
	input wire logic ring_osc_a,
	input wire logic ring_osc_b,
	input wire logic tamper_erase_input,
	input wire logic mesh_breach,
	input wire logic vec_fetch,
	input wire logic [5:0] vec_addr,
	output logic [7:0] vec_data,
	output var loader_pkg::mem_req_s mem_req,
	input wire logic [7:0] mem_rdata,
	output logic [63:0] key_out,
	output logic crypt_block,
	output logic memory_bus_supply_out,
	output logic scratch_we,
	output logic [6:0] scratch_addr
);

	localparam logic [15:0] MEM_LAST = 16'(MEM_WORDS - 1);
	localparam logic [7:0] SCR_LAST = 8'(SCRATCH_CLR - 1);
	localparam logic [7:0] BUS_OFF = 8'(`BUS_OFF_CYC);

	loader_pkg::cmd_state_e st_r;
	loader_pkg::sweep_e sw_r;
	logic [15:0] cnt_r;
	logic [7:0] op_r;
	logic rd_pend_r;
	logic [2:0] lock_r;
	logic key_inst_r;
	logic key_valid_r;
	logic sealed_r;
	logic erase_pend_r;
	logic [7:0] bus_off_r;
	logic mode_q_r;
	logic [15:0] lfsr_r;
	logic [63:0] cand_r;
	logic [6:0] cand_cnt_r;
	logic scr_busy_r;
	logic [7:0] scr_cnt_r;
	logic [15:0] addr_r;
	logic [7:0] data_r;
	logic [1:0] sfr_sel_r;
	logic [15:0] result_r;
	logic [15:0] crc_r;
	logic [7:0] last_cmd_r;
	logic refused_r;
	logic mismatch_r;
	logic [7:0] nv_r [`NV_COUNT];
	logic [7:0] vec_r [`VEC_BYTES];
	logic [31:0] rd_mux;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] x;
		x = c;
		for (int b = 7; b >= 0; b--) begin
			if (x[15] ^ d[b]) begin
				x = {x[14:0], 1'b0} ^ `CRC_POLY;
			end else begin
				x = {x[14:0], 1'b0};
			end
		end
		return x;
	endfunction : crc_step

	logic wb_hit, wb_wr, cmd_wr;
	logic [7:0] letter;
	logic lock_set, lock_broken, kill;
	logic accept, is_mem, mem_ok;
	logic go_mem, go_u, go_n, go_z, go_rw, refuse;
	logic cand_ready, sess_start, cand_restart, key_load, wipe, erase_start;

	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_hit & wb_we_i;
	assign cmd_wr = wb_wr & wb_sel_i[0] & (wb_adr_i == `REG_CMD);
	assign letter = wb_dat_i[7:0];
	assign lock_set = &lock_r;
	assign lock_broken = (|lock_r) & ~lock_set;
	assign kill = tamper_erase_input | mesh_breach | lock_broken;
	assign cand_ready = (cand_cnt_r == 7'(`KEY_BITS));
	assign sess_start = loader_mode & ~mode_q_r;
	assign accept = cmd_wr & (st_r == loader_pkg::ST_IDLE) & ~kill & ~erase_pend_r
		& memory_bus_supply_out & mode_q_r;
	assign is_mem = (letter == `LTR_F) | (letter == `LTR_L) | (letter == `LTR_D)
		| (letter == `LTR_V) | (letter == `LTR_C);
	assign mem_ok = ~lock_set & cand_ready;
	assign go_mem = accept & is_mem & mem_ok;
	assign go_u = accept & (letter == `LTR_U);
	assign go_n = accept & (letter == `LTR_N);
	assign go_z = accept & (letter == `LTR_Z);
	assign go_rw = accept & ((letter == `LTR_R) | (letter == `LTR_W));
	assign refuse = accept & ~(go_mem | go_u | go_n | go_z | go_rw);
	assign key_load = (go_mem & ~key_inst_r) | ((st_r == loader_pkg::ST_FRESH) & cand_ready);
	assign wipe = kill | go_u | go_n;
	assign cand_restart = sess_start | go_u | kill;
	assign erase_start = (st_r == loader_pkg::ST_IDLE) & erase_pend_r & ~kill
		& memory_bus_supply_out & (bus_off_r == 8'h00);

	always_ff @(posedge clk) begin
		mode_q_r <= rst ? 1'b0 : loader_mode;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lfsr_r <= `LFSR_SEED;
		end else begin
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		end
	end

	always_ff @(posedge clk) begin
		if (rst || cand_restart) begin
			cand_r <= '0;
			cand_cnt_r <= '0;
		end else if (!cand_ready) begin
			cand_r <= {cand_r[62:0], ring_osc_a ^ ring_osc_b ^ lfsr_r[0]};
			cand_cnt_r <= cand_cnt_r + 7'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || wipe) begin
			key_out <= '0;
			key_valid_r <= 1'b0;
		end else if (key_load) begin
			key_out <= cand_r;
			key_valid_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || wipe || !loader_mode) begin
			key_inst_r <= 1'b0;
		end else if (key_load) begin
			key_inst_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || wipe) begin
			lock_r <= 3'b000;
		end else if (go_z) begin
			lock_r <= 3'b111;
		end
	end

	always_ff @(posedge clk) begin
		crypt_block <= rst ? 1'b0 : lock_set;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sealed_r <= 1'b0;
		end else if (go_n) begin
			sealed_r <= 1'b1;
		end else if (key_load) begin
			sealed_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			erase_pend_r <= 1'b0;
		end else if (kill) begin
			erase_pend_r <= 1'b1;
		end else if (erase_start) begin
			erase_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_off_r <= '0;
			memory_bus_supply_out <= 1'b1;
		end else if (tamper_erase_input) begin
			bus_off_r <= BUS_OFF;
			memory_bus_supply_out <= 1'b0;
		end else if (bus_off_r > 8'h01) begin
			bus_off_r <= bus_off_r - 8'h01;
		end else begin
			bus_off_r <= '0;
			memory_bus_supply_out <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			scr_busy_r <= 1'b0;
			scr_cnt_r <= '0;
			scratch_we <= 1'b0;
			scratch_addr <= '0;
		end else if (sess_start) begin
			scr_busy_r <= 1'b1;
			scr_cnt_r <= '0;
			scratch_we <= 1'b0;
		end else begin
			scratch_we <= scr_busy_r;
			scratch_addr <= scr_cnt_r[6:0];
			if (scr_busy_r) begin
				scr_cnt_r <= scr_cnt_r + 8'h01;
				scr_busy_r <= (scr_cnt_r != SCR_LAST);
			end
		end
	end

	// command engine; tamper outranks everything but rst
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= loader_pkg::ST_IDLE;
			sw_r <= loader_pkg::SW_FILL;
			cnt_r <= '0;
			op_r <= '0;
			rd_pend_r <= 1'b0;
			mem_req <= '0;
		end else if (kill) begin
			st_r <= loader_pkg::ST_IDLE;
			rd_pend_r <= 1'b0;
			mem_req <= '0;
		end else begin
			mem_req <= '0;
			rd_pend_r <= 1'b0;
			unique case (st_r)
				loader_pkg::ST_IDLE: begin
					if (erase_start || go_u) begin
						st_r <= loader_pkg::ST_SWEEP;
						sw_r <= loader_pkg::SW_ERASE;
						cnt_r <= '0;
					end else if (go_n) begin
						st_r <= loader_pkg::ST_SWEEP;
						sw_r <= loader_pkg::SW_SEAL;
						cnt_r <= '0;
					end else if (go_mem) begin
						op_r <= letter;
						cnt_r <= '0;
						if (letter == `LTR_F) begin
							st_r <= loader_pkg::ST_SWEEP;
							sw_r <= loader_pkg::SW_FILL;
						end else if (letter == `LTR_C) begin
							st_r <= loader_pkg::ST_SWEEP;
							sw_r <= loader_pkg::SW_CRC;
						end else begin
							st_r <= loader_pkg::ST_ISSUE;
						end
					end else if (vec_fetch && memory_bus_supply_out) begin
						mem_req.re <= 1'b1;
						mem_req.addr <= lfsr_r;
					end
				end
				loader_pkg::ST_SWEEP: begin
					mem_req.addr <= cnt_r;
					if (sw_r == loader_pkg::SW_CRC) begin
						mem_req.re <= 1'b1;
						rd_pend_r <= 1'b1;
					end else begin
						mem_req.we <= 1'b1;
						mem_req.wdata <= (sw_r == loader_pkg::SW_FILL) ? data_r : 8'h00;
					end
					if (cnt_r == MEM_LAST) begin
						if (sw_r == loader_pkg::SW_ERASE) begin
							st_r <= loader_pkg::ST_FRESH;
						end else begin
							st_r <= loader_pkg::ST_WAIT;
						end
					end else begin
						cnt_r <= cnt_r + 16'h0001;
					end
				end
				loader_pkg::ST_ISSUE: begin
					mem_req.addr <= addr_r;
					if (op_r == `LTR_L) begin
						mem_req.we <= 1'b1;
						mem_req.wdata <= data_r;
					end else begin
						mem_req.re <= 1'b1;
						rd_pend_r <= 1'b1;
					end
					st_r <= loader_pkg::ST_WAIT;
				end
				loader_pkg::ST_WAIT: begin
					st_r <= loader_pkg::ST_IDLE;
				end
				loader_pkg::ST_FRESH: begin
					if (cand_ready) begin
						st_r <= loader_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			crc_r <= `CRC_INIT;
			result_r <= '0;
			mismatch_r <= 1'b0;
		end else if (accept) begin
			crc_r <= `CRC_INIT;
			mismatch_r <= 1'b0;
			if (go_rw && letter == `LTR_R) begin
				result_r <= {8'h00, nv_r[sfr_sel_r]};
				if (sfr_sel_r == 2'(`NV_LOCK_IDX)) begin
					result_r[0] <= lock_set;
				end
			end
		end else if (rd_pend_r) begin
			if (op_r == `LTR_C) begin
				crc_r <= crc_step(crc_r, mem_rdata);
				result_r <= crc_step(crc_r, mem_rdata);
			end else if (op_r == `LTR_D) begin
				result_r <= {8'h00, mem_rdata};
			end else if (mem_rdata != data_r) begin
				mismatch_r <= 1'b1;
			end
		end
	end

	for (genvar n = 0; n < `NV_COUNT; n++) begin : g_nv
		always_ff @(posedge clk) begin
			if (rst) begin
				nv_r[n] <= `NV_RST;
			end else if (go_rw && letter == `LTR_W && sfr_sel_r == 2'(n)) begin
				nv_r[n] <= data_r;
			end
		end
	end

	for (genvar i = 0; i < `VEC_BYTES; i++) begin : g_vec
		always_ff @(posedge clk) begin
			if (rst || wipe) begin
				vec_r[i] <= '0;
			end else if (st_r == loader_pkg::ST_ISSUE && op_r == `LTR_L && addr_r == 16'(i)) begin
				vec_r[i] <= data_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			vec_data <= '0;
		end else if (vec_fetch) begin
			vec_data <= (vec_addr < 6'(`VEC_BYTES)) ? vec_r[vec_addr] : 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			refused_r <= 1'b0;
			last_cmd_r <= '0;
		end else if (accept) begin
			refused_r <= refuse;
			last_cmd_r <= letter;
		end else if (cmd_wr) begin
			// busy, killed, erase pending, supply off or no session: command dropped
			refused_r <= 1'b1;
			last_cmd_r <= letter;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			addr_r <= '0;
			data_r <= '0;
			sfr_sel_r <= '0;
		end else if (wb_wr) begin
			if (wb_adr_i == `REG_ADDR && wb_sel_i[0]) addr_r[7:0] <= wb_dat_i[7:0];
			if (wb_adr_i == `REG_ADDR && wb_sel_i[1]) addr_r[15:8] <= wb_dat_i[15:8];
			if (wb_adr_i == `REG_DATA && wb_sel_i[0]) data_r <= wb_dat_i[7:0];
			if (wb_adr_i == `REG_SFR_SEL && wb_sel_i[0]) sfr_sel_r <= wb_dat_i[1:0];
		end
	end

	always_comb begin
		rd_mux = '0;
		unique case (wb_adr_i)
			`REG_CMD: rd_mux[7:0] = last_cmd_r;
			`REG_STATUS: begin
				rd_mux[`ST_LOCK] = lock_set;
				rd_mux[`ST_BUSY] = (st_r != loader_pkg::ST_IDLE);
				rd_mux[`ST_KEY_VALID] = key_valid_r;
				rd_mux[`ST_CAND_READY] = cand_ready;
				rd_mux[`ST_REFUSED] = refused_r;
				rd_mux[`ST_MISMATCH] = mismatch_r;
				rd_mux[`ST_SEALED] = sealed_r;
				rd_mux[`ST_SESSION] = mode_q_r;
				rd_mux[`ST_ERASE_PEND] = erase_pend_r;
				rd_mux[`ST_SUPPLY] = memory_bus_supply_out;
			end
			`REG_ADDR: rd_mux[15:0] = addr_r;
			`REG_DATA: rd_mux[7:0] = data_r;
			`REG_RESULT: rd_mux[15:0] = result_r;
			`REG_SFR_SEL: rd_mux[1:0] = sfr_sel_r;
			default: rd_mux = '0;
		endcase
	end

	// unmapped addresses still ack, read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_hit;
			if (wb_hit && !wb_we_i) wb_dat_o <= rd_mux;
		end
	end

endmodule : secure_loader_key_lock_manager
`default_nettype wire

// File: loader_params.svh
/*
 constants of the secure loader key/lock block: register offsets,
 status bit positions, command letters, sizes and timing counts.
 assumes the including file runs at the 40 MHz clk.
*/
`ifndef LOADER_PARAMS_SVH
`define LOADER_PARAMS_SVH

`define REG_CMD 8'h00
`define REG_STATUS 8'h04
`define REG_ADDR 8'h08
`define REG_DATA 8'h0C
`define REG_RESULT 8'h10
`define REG_SFR_SEL 8'h14

`define ST_LOCK 0
`define ST_BUSY 1
`define ST_KEY_VALID 2
`define ST_CAND_READY 3
`define ST_REFUSED 4
`define ST_MISMATCH 5
`define ST_SEALED 6
`define ST_SESSION 7
`define ST_ERASE_PEND 8
`define ST_SUPPLY 9

`define LTR_C 8'h43
`define LTR_D 8'h44
`define LTR_F 8'h46
`define LTR_L 8'h4C
`define LTR_N 8'h4E
`define LTR_R 8'h52
`define LTR_U 8'h55
`define LTR_V 8'h56
`define LTR_W 8'h57
`define LTR_Z 8'h5A

`define KEY_BITS 64
`define VEC_BYTES 48
`define SCRATCH_BYTES 128
`define SCRATCH_CLR_DEF 32
`define MEM_WORDS_DEF 65536
`define NV_COUNT 4
`define NV_LOCK_IDX 2
`define NV_RST 8'h00
`define LFSR_SEED 16'hACE1
`define CRC_POLY 16'h8005
`define CRC_INIT 16'h0000

`define CLK_MHZ 40
`define BUS_OFF_NS 1000
`define BUS_OFF_CYC ((`BUS_OFF_NS * `CLK_MHZ + 999) / 1000)

`endif

// File: loader_pkg.sv
/*
 types of the secure loader key/lock block: engine states, sweep kinds
 and the external memory request bundle.
 assumes nothing beyond a SystemVerilog compiler.
*/
package loader_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SWEEP = 3'b001,
		ST_ISSUE = 3'b010,
		ST_WAIT = 3'b011,
		ST_FRESH = 3'b100
	} cmd_state_e;

	typedef enum logic [1:0] {
		SW_FILL = 2'b00,
		SW_CRC = 2'b01,
		SW_ERASE = 2'b10,
		SW_SEAL = 2'b11
	} sweep_e;

	typedef struct packed {
		logic re;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_s;

endpackage : loader_pkg

// File: loader_mem_model.sv
/*
 behavioural external ram of 64 bytes for the loader's memory bus.
 assumes mem_req changes on clk rising edges; read data stands while re
 is high, so the loader takes it at the edge that ends the re cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module loader_mem_model (
	input wire logic clk,
	input wire loader_pkg::mem_req_s mem_req,
	output logic [7:0] mem_rdata
);
	logic [7:0] ram [64];
	logic [7:0] held_r = 8'h00;
	always_ff @(posedge clk) begin
		if (mem_req.we) begin
			ram[mem_req.addr[5:0]] <= mem_req.wdata;
		end
	end
	// true bytes back
	// an undriven bus must not look like a held value
	always_ff @(posedge clk) begin
		held_r <= mem_rdata;
	end
	assign mem_rdata = mem_req.re ? ram[mem_req.addr[5:0]] : ~held_r;
endmodule : loader_mem_model
`default_nettype wire

// File: loader_chk.sv
/*
 concurrent checks on the loader's ports.
 assumes one clk domain with synchronous active high rst.
*/
`timescale 1ns/1ps
`default_nettype none
module loader_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic loader_mode,
	input wire logic tamper_erase_input,
	input wire logic mesh_breach,
	input wire loader_pkg::mem_req_s mem_req,
	input wire logic [63:0] key_out,
	input wire logic memory_bus_supply_out,
	input wire logic scratch_we
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_reset_state: assert property ($fell(rst) |-> !wb_ack_o && key_out == '0 && memory_bus_supply_out)
		else $error("bad state after reset");
	a_tamper_wipe: assert property (tamper_erase_input |=> key_out == '0 && !mem_req.we)
		else $error("tamper left key or write");
	a_supply_drop: assert property (tamper_erase_input |=> !memory_bus_supply_out)
		else $error("supply kept during tamper");
	a_supply_hold: assert property ($fell(tamper_erase_input) |-> !memory_bus_supply_out [*8])
		else $error("supply back too soon");
	a_mesh_wipe: assert property (mesh_breach |=> key_out == '0)
		else $error("breach left key");
	a_sweep_step: assert property (mem_req.we && $past(mem_req.we) |-> mem_req.addr == $past(mem_req.addr) + 16'h0001)
		else $error("sweep skipped an address");
	a_scratch_clear: assert property ($rose(loader_mode) |-> ##[1:300] scratch_we)
		else $error("no scratch clear on entry");
	cover property (mem_req.we && $past(mem_req.we));
	cover property (tamper_erase_input);
	cover property ($rose(wb_ack_o));
endmodule : loader_chk
bind secure_loader_key_lock_manager loader_chk u_chk (.clk, .rst, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .loader_mode, .tamper_erase_input, .mesh_breach, .mem_req, .key_out,
	.memory_bus_supply_out, .scratch_we);
`default_nettype wire

// File: secure_loader_key_lock_manager_bench.sv
/*
 directed bench: wishbone command sequences with expected values.
 assumes the loader and the 64-byte memory model; MEM_WORDS set to 64.
*/
`timescale 1ns/1ps
`default_nettype none
`include "loader_params.svh"
module secure_loader_key_lock_manager_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = '0;
	logic loader_mode = 1'b0, ring_osc_a = 1'b0, ring_osc_b = 1'b0;
	logic tamper_erase_input = 1'b0, mesh_breach = 1'b0, vec_fetch = 1'b0;
	logic [5:0] vec_addr = '0;
	logic [31:0] wb_dat_o, q;
	logic wb_ack_o, crypt_block, memory_bus_supply_out, scratch_we;
	logic [7:0] vec_data, mem_rdata;
	loader_pkg::mem_req_s mem_req;
	logic [63:0] key_out, k0;
	logic [6:0] scratch_addr;
	logic [3:0] osc_cnt = '0;
	int error_cnt = 0;
	int n_tests = 0;
	int scr_n = 0;

	secure_loader_key_lock_manager #(.MEM_WORDS(64), .SCRATCH_CLR(32)) u_dut (.clk, .rst,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .loader_mode, .ring_osc_a, .ring_osc_b, .tamper_erase_input,
		.mesh_breach, .vec_fetch, .vec_addr, .vec_data, .mem_req, .mem_rdata, .key_out,
		.crypt_block, .memory_bus_supply_out, .scratch_we, .scratch_addr);
	loader_mem_model u_mem (.clk, .mem_req, .mem_rdata);

	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		osc_cnt <= osc_cnt + 4'h1;
		ring_osc_a <= osc_cnt[1];
		ring_osc_b <= osc_cnt[0] ^ osc_cnt[3];
	end
	// scratch cleared in address order, 32 per session
	always @(posedge clk) begin
		if (scratch_we === 1'b1) begin
			chk(scratch_addr, 7'(scr_n % 32));
			scr_n <= scr_n + 1;
		end
	end

	task close_out;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	task chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		if (n >= 50) error_cnt++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task st_bit(input int b, input logic e);
		wb(1'b0, `REG_STATUS, '0);
		chk(q[b], e);
	endtask : st_bit

	// sweeps plus 40-cycle bus-off fit well inside the bound
	task idle;
		int n;
		n = 0;
		do begin
			wb(1'b0, `REG_STATUS, '0);
			n++;
		end while ((q[`ST_BUSY] !== 1'b0 || q[`ST_ERASE_PEND] !== 1'b0 ||
			q[`ST_SUPPLY] !== 1'b1) && n < 400);
		if (n >= 400) error_cnt++;
	endtask : idle

	task cmd(input logic [7:0] c);
		wb(1'b1, `REG_CMD, 32'(c));
		idle;
	endtask : cmd

	task ramv(input logic [7:0] v);
		for (int i = 0; i < 64; i++) chk(u_mem.ram[i], v);
	endtask : ramv

	function automatic logic [15:0] crc_fill(input logic [7:0] b);
		logic [15:0] c;
		c = `CRC_INIT;
		for (int i = 0; i < 64; i++) begin
			for (int j = 7; j >= 0; j--) begin
				c = {c[14:0], 1'b0} ^ ((c[15] ^ b[j]) ? `CRC_POLY : 16'h0000);
			end
		end
		return c;
	endfunction : crc_fill

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		st_bit(`ST_SUPPLY, 1'b1);
		wb(1'b1, `REG_CMD, 32'(`LTR_L));
		st_bit(`ST_REFUSED, 1'b1);
		loader_mode <= 1'b1;
		repeat (80) @(posedge clk);
		wb(1'b1, `REG_ADDR, 32'h0000_0005);
		wb(1'b1, `REG_DATA, 32'h0000_00A5);
		cmd(`LTR_L);
		chk(u_mem.ram[5], 8'hA5);
		chk(key_out != '0, 1'b1);
		k0 = key_out;
		vec_addr <= 6'h05;
		vec_fetch <= 1'b1;
		@(posedge clk);
		#1;
		chk(vec_data, 8'hA5);
		chk(mem_req.re, 1'b1);
		@(posedge clk);
		vec_fetch <= 1'b0;
		cmd(`LTR_D);
		wb(1'b0, `REG_RESULT, '0);
		chk(q, 32'h0000_00A5);
		for (int i = 0; i < 2; i++) begin
			wb(1'b1, `REG_DATA, i ? 32'h0000_003C : 32'h0000_00A5);
			cmd(`LTR_V);
			st_bit(`ST_MISMATCH, i[0]);
		end
		wb(1'b1, `REG_DATA, 32'h0000_0011);
		cmd(`LTR_F);
		ramv(8'h11);
		cmd(`LTR_C);
		wb(1'b0, `REG_RESULT, '0);
		chk(q[15:0], crc_fill(8'h11));
		chk(key_out, k0);
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, `REG_SFR_SEL, i);
			wb(1'b1, `REG_DATA, 32'h0000_0020 + 32'(2 * i));
			cmd(`LTR_W);
			cmd(`LTR_R);
			wb(1'b0, `REG_RESULT, '0);
			chk(q[7:0], 8'h20 + 8'(2 * i));
		end
		cmd(`LTR_Z);
		st_bit(`ST_LOCK, 1'b1);
		chk(crypt_block, 1'b1);
		wb(1'b1, `REG_CMD, 32'(`LTR_L));
		st_bit(`ST_REFUSED, 1'b1);
		wb(1'b1, `REG_CMD, 32'(`LTR_U));
		chk(key_out, '0);
		idle;
		ramv(8'h00);
		st_bit(`ST_LOCK, 1'b0);
		vec_fetch <= 1'b1;
		@(posedge clk);
		#1;
		chk(vec_data, 8'h00);
		@(posedge clk);
		vec_fetch <= 1'b0;
		chk(key_out != k0 && key_out != '0, 1'b1);
		wb(1'b1, `REG_DATA, 32'h0000_0077);
		wb(1'b1, `REG_CMD, 32'(`LTR_F));
		tamper_erase_input <= 1'b1;
		repeat (3) @(posedge clk);
		chk(memory_bus_supply_out, 1'b0);
		st_bit(`ST_ERASE_PEND, 1'b1);
		tamper_erase_input <= 1'b0;
		idle;
		ramv(8'h00);
		cmd(`LTR_Z);
		mesh_breach <= 1'b1;
		@(posedge clk);
		mesh_breach <= 1'b0;
		idle;
		st_bit(`ST_LOCK, 1'b0);
		loader_mode <= 1'b0;
		repeat (4) @(posedge clk);
		st_bit(`ST_SESSION, 1'b0);
		loader_mode <= 1'b1;
		repeat (80) @(posedge clk);
		k0 = key_out;
		cmd(`LTR_F);
		chk(key_out != k0 && key_out != '0, 1'b1);
		cmd(`LTR_N);
		st_bit(`ST_SEALED, 1'b1);
		chk(key_out, '0);
		chk(scr_n, 64);
		close_out;
	end

	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		close_out;
	end
endmodule : secure_loader_key_lock_manager_bench
`default_nettype wire
